// ---- rtl/rmb_pkg.sv ----
// shared constants, types and register map of the register mapping data broker
`default_nettype none
package rmb_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NIF = 3;               // interfaces: fieldbus, serial_data_port, shift_chain_port
  localparam int IF_FB = 0;
  localparam int IF_SDP = 1;
  localparam int IF_SCP = 2;
  localparam int WORD_W = 16;           // every store register is one 16-bit word
  localparam int IDX_W = 9;             // index into the word store
  localparam int STORE_WORDS = 288;     // implemented register numbers 1..288
  localparam logic [15:0] STORE_LAST_REG = 16'h0120;
  localparam int REGION_WORDS = 16;     // words per input and per output region
  localparam int SMAP_AREAS = 8;
  localparam int XMAP_AREAS = 16;
  localparam logic [10:0] XMAP_MAX_BITS = 11'h400;

  // ----------------------------------------------------------------
  // register map (register numbers, numbering starts at 1)
  // ----------------------------------------------------------------
  localparam logic [15:0] LED_CFG_REG = 16'h0025;    // status indicator shift output config
  localparam logic [15:0] VALID_TIME_REG = 16'h0030; // +p: producer validity time in ticks, 0 = off
  localparam logic [15:0] SUBST_MODE_REG = 16'h0034; // +c: consumer substitute mode
  localparam logic [15:0] SMAP_REG = 16'h0040;       // +c*16+a*2: source reg, +1: length/swap
  localparam logic [15:0] XMAP_REG = 16'h0070;       // +e*4: src reg, dst reg, bit positions, count
  localparam logic [15:0] IN_BASE_REG = 16'h00B0;    // +p*16: input region of interface p
  localparam logic [15:0] OUT_BASE_REG = 16'h00E0;   // +c*16: output region of interface c
  localparam logic [15:0] IO_SPAN = 16'h0030;        // three regions of sixteen words

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int LED_EN_BIT = 0;        // led config: route indicators to first shift register
  localparam int SWAP_BIT = 15;         // simple map length word: 0x8000 swaps bytes
  localparam int XPOS_SRC_LSB = 0;      // bit positions word: [3:0] source bit
  localparam int XPOS_DST_LSB = 4;      // bit positions word: [7:4] target bit
  localparam logic [15:0] STORE_RST = 16'h0000;
  localparam int LED_RUN = 0;
  localparam int LED_ERR = 1;
  localparam int LED_SCR_RUN = 2;
  localparam int LED_SCR_ERR = 3;
  localparam int LED_FB_RUN = 4;
  localparam int LED_FB_STOP = 5;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 100;
  localparam int VALID_TICK_NS = 100_000;          // validity timer tick, 100 us
  localparam int VALID_TICK_CYC_DEF = VALID_TICK_NS / CLK_NS;
  localparam int FLASH_HALF_NS = 250_000_000;      // indicator flash half period, 250 ms
  localparam int FLASH_HALF_CYC_DEF = FLASH_HALF_NS / CLK_NS;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SUBST_ZERO = 2'b00,
    SUBST_ONES = 2'b01,
    SUBST_KEEP = 2'b10
  } rmb_subst_t;

  typedef struct packed {
    logic [IDX_W-1:0] idx;
    logic [WORD_W-1:0] data;
  } rmb_wr_t;

  typedef struct packed {
    logic sys_running;
    logic sys_initialising;
    logic cfg_fault;
    logic internal_fault;
    logic script_running;
    logic script_fault;
    logic fb_exchange;
    logic fb_clear_data;
    logic fb_offline;
  } rmb_status_t;

endpackage
`default_nettype wire

// ---- rtl/rmb_flash.sv ----
// free running flash phase for the status indicators
`default_nettype none
module rmb_flash #(
  parameter int unsigned HALF_CYC = 2500000
) (
  input wire logic clk,     // module clock
  input wire logic resetn,  // synchronous reset, active low
  output logic flash_q      // flash phase, toggles every HALF_CYC cycles
);
  localparam logic [31:0] LAST = 32'(HALF_CYC - 1);

  typedef struct packed {
    logic [31:0] cnt;
    logic ph;
  } rmb_flash_st_t;

  rmb_flash_st_t s_q, s_d;

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  // fixed rate from the module clock
  always_comb begin
    s_d = s_q;
    if (s_q.cnt == LAST) begin
      s_d.cnt = 32'h0000_0000;
      s_d.ph = ~s_q.ph;
    end else begin
      s_d.cnt = s_q.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign flash_q = s_q.ph;
endmodule
`default_nettype wire

// ---- rtl/rmb_skid.sv ----
// small fifo between the mapping engine and the store write port
`default_nettype none
module rmb_skid #(
  parameter int unsigned W = 25,
  parameter int unsigned DEPTH = 2
) (
  input wire logic clk,             // module clock
  input wire logic resetn,          // synchronous reset, active low
  input wire logic in_valid,        // producer offers a word
  input wire logic [W-1:0] in_data,  // offered word
  output logic in_ready,            // room for a word
  output logic out_valid,           // a word is waiting
  output logic [W-1:0] out_data,     // oldest word
  input wire logic out_ready,       // drain side takes the word
  output logic empty                // nothing held
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LASTP = AW'(DEPTH - 1);
  localparam logic [AW:0] FULLC = (AW + 1)'(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } rmb_skid_st_t;

  rmb_skid_st_t s_q, s_d;
  logic [W-1:0] mem_q [DEPTH];
  logic do_push, do_pop;

  assign in_ready = (s_q.cnt != FULLC);
  assign out_valid = (s_q.cnt != '0);
  assign empty = (s_q.cnt == '0);
  assign out_data = mem_q[s_q.rp];
  assign do_push = in_valid && in_ready;
  assign do_pop = out_valid && out_ready;

  // ----------------------------------------------------------------
  // pointers
  // ----------------------------------------------------------------
  // full stops the engine, so a stalled drain loses nothing
  always_comb begin
    s_d = s_q;
    if (do_push) begin
      s_d.wp = (s_q.wp == LASTP) ? '0 : s_q.wp + 1'b1;
    end
    if (do_pop) begin
      s_d.rp = (s_q.rp == LASTP) ? '0 : s_q.rp + 1'b1;
    end
    if (do_push && !do_pop) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end else if (do_pop && !do_push) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // storage needs no reset, count guards it
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem_q[s_q.wp] <= in_data;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/rmb_broker.sv ----
// register store and mapping engine of the data broker, with status indicators
// How it works
// - bit0 off stopped, flash init, on running
// - bit1 off ok, flash config fault, on internal
// - bit2 flash idle, on running; bit3 script fault
// - bit4 exchange/standby flash; bit5 bus offline
// - indicators reach shift register only when enabled
// - every store register is 16 bits wide
// - byte values one register, 32-bit two
// - words held little endian in the store
// - numbering starts at one, subset implemented
// - up to eight simple areas per interface
// - simple area copies equal length from inputs
// - simple targets packed from lowest output register
// - failed provider gets substitute values written
// - length flag 0x8000 swaps bytes of words
// - sixteen extended areas, each a bit count
// - extended area at most 1024 bits
// - extended target output register and bit 0-15
// - extended source register plus start bit
// - simple areas first, then extended, each cycle
// - overlapping writes allowed, no conflict flagged
// - per producer validity timer restarted on data
// - substitute zeros, ones or last valid data
`default_nettype none
module rmb_broker #(
  parameter int unsigned FLASH_HALF_CYC = rmb_pkg::FLASH_HALF_CYC_DEF,
  parameter int unsigned VALID_TICK_CYC = rmb_pkg::VALID_TICK_CYC_DEF
) (
  input wire logic clk,                          // module clock, 10 MHz
  input wire logic resetn,                       // synchronous reset, active low
  input wire logic cfg_req,                      // config_debug_port access strobe
  input wire logic cfg_we,                       // 1 write, 0 read
  input wire logic [15:0] cfg_addr,              // register number
  input wire logic [rmb_pkg::WORD_W-1:0] cfg_wdata, // write word
  output logic [rmb_pkg::WORD_W-1:0] cfg_rdata_q, // read word
  output logic cfg_ack_q,                        // access done
  input wire logic if_we,                        // interface writes its input region
  input wire logic [1:0] if_be,                  // byte lanes, bit0 = low byte
  input wire logic [15:0] if_addr,               // register number of the write
  input wire logic [rmb_pkg::WORD_W-1:0] if_wdata, // written word
  input wire logic [15:0] if_rd_addr,            // register number the interfaces read
  output logic [rmb_pkg::WORD_W-1:0] if_rdata_q,  // word at if_rd_addr
  input wire rmb_pkg::rmb_status_t status_in,    // module and bus conditions
  output logic [7:0] shift_out0_q,               // first output shift register
  output logic [5:0] status_led_q,               // indicator bits
  output logic [rmb_pkg::NIF-1:0] producer_valid_q, // producer data still fresh
  output logic map_cycle_done_q                  // pulse after each full mapping pass
);
  import rmb_pkg::*;

  typedef enum logic [2:0] {
    ST_SIMPLE = 3'b001,
    ST_EXT = 3'b010,
    ST_WRAP = 3'b100
  } rmb_eng_t;

  typedef struct packed {
    rmb_eng_t st;
    logic [1:0] cons;
    logic [3:0] area;
    logic [14:0] idx;
    logic [4:0] dst_off;
    logic [15:0] tick;
    logic [NIF-1:0][15:0] tmr;
    logic [NIF-1:0] valid;
    logic [15:0] rdata;
    logic ack;
    logic [15:0] if_rdata;
    logic [7:0] sh_out;
    logic [5:0] led;
    logic done;
  } rmb_state_t;

  localparam logic [15:0] TICK_LAST = 16'(VALID_TICK_CYC - 1);
  localparam logic [1:0] LAST_CONS = 2'(NIF - 1);
  localparam logic [3:0] LAST_SAREA = 4'(SMAP_AREAS - 1);
  localparam logic [3:0] LAST_XAREA = 4'(XMAP_AREAS - 1);
  localparam logic [4:0] REGION_END = 5'(REGION_WORDS);

  rmb_state_t s_q, s_d;
  // every store entry is one 16-bit word
  logic [WORD_W-1:0] store_q [STORE_WORDS];

  logic flash;
  logic push, buf_ready, buf_valid, buf_empty, drain;
  rmb_wr_t push_w, pop_w;
  logic [$bits(rmb_wr_t)-1:0] buf_out;
  logic [15:0] sm_src, sm_len, src_r, dst_r, src_w, mode_w;
  logic [15:0] x_src, x_dst, x_pos, x_cnt, x_sw, x_dw, led_cfg_w, scp_w;
  logic [10:0] x_lim;
  logic [19:0] sbit, dbit;
  logic [2:0] phit, chit, wr_hit;
  logic cfg_wr, bad_src, bitv;
  logic [1:0] dcons;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // number zero and numbers above the store read zero
  function automatic logic [15:0] rd_word(input logic [15:0] r);
    logic [15:0] i;
    i = r - 16'h0001;
    if (r == 16'h0000 || r > STORE_LAST_REG) begin
      return 16'h0000;
    end
    return store_q[i[IDX_W-1:0]];
  endfunction

  // one-hot region hit within three consecutive sixteen-word regions
  function automatic logic [2:0] region_hit(input logic [15:0] r, input logic [15:0] base);
    logic [15:0] off;
    off = r - base;
    region_hit = 3'b000;
    if (r >= base && off < IO_SPAN) begin
      region_hit[off[5:4]] = 1'b1;
    end
  endfunction

  function automatic logic [IDX_W-1:0] to_idx(input logic [15:0] r);
    return IDX_W'(r - 16'h0001);
  endfunction

  // ----------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------
  rmb_flash #(.HALF_CYC(FLASH_HALF_CYC)) u_flash (
    .clk(clk),
    .resetn(resetn),
    .flash_q(flash)
  );

  // host and interface writes take the store port first, so the buffer
  // really fills and the engine stalls behind it
  rmb_skid #(.W($bits(rmb_wr_t)), .DEPTH(2)) u_skid (
    .clk(clk),
    .resetn(resetn),
    .in_valid(push),
    .in_data(push_w),
    .in_ready(buf_ready),
    .out_valid(buf_valid),
    .out_data(buf_out),
    .out_ready(drain),
    .empty(buf_empty)
  );

  assign pop_w = rmb_wr_t'(buf_out);
  assign cfg_wr = cfg_req && cfg_we && cfg_addr != 16'h0000 && cfg_addr <= STORE_LAST_REG;
  assign drain = !cfg_wr && !if_we;

  // ----------------------------------------------------------------
  // mapping fetch
  // ----------------------------------------------------------------
  // decode of the current simple and extended area descriptors
  always_comb begin
    sm_src = rd_word(SMAP_REG + {10'h000, s_q.cons, s_q.area[2:0], 1'b0});
    sm_len = rd_word(SMAP_REG + {10'h000, s_q.cons, s_q.area[2:0], 1'b1});
    // source walks in step with the target
    src_r = sm_src + {1'b0, s_q.idx};
    // targets packed from the region base
    dst_r = OUT_BASE_REG + {10'h000, s_q.cons, 4'h0} + {11'h000, s_q.dst_off};
    src_w = rd_word(src_r);
    x_src = rd_word(XMAP_REG + {10'h000, s_q.area, 2'b00});
    x_dst = rd_word(XMAP_REG + {10'h000, s_q.area, 2'b01});
    x_pos = rd_word(XMAP_REG + {10'h000, s_q.area, 2'b10});
    x_cnt = rd_word(XMAP_REG + {10'h000, s_q.area, 2'b11});
    // longer areas are cut at 1024 bits
    x_lim = (x_cnt > {5'h00, XMAP_MAX_BITS}) ? XMAP_MAX_BITS : x_cnt[10:0];
    dbit = {x_dst, 4'h0} + {16'h0000, x_pos[XPOS_DST_LSB +: 4]} + {9'h000, s_q.idx[10:0]};
    sbit = {x_src, 4'h0} + {16'h0000, x_pos[XPOS_SRC_LSB +: 4]} + {9'h000, s_q.idx[10:0]};
    x_sw = rd_word(sbit[19:4]);
    x_dw = rd_word(dbit[19:4]);
    bitv = x_sw[sbit[3:0]];
    chit = region_hit(dbit[19:4], OUT_BASE_REG);
    dcons = chit[2] ? 2'd2 : (chit[1] ? 2'd1 : 2'd0);
    phit = region_hit(s_q.st == ST_EXT ? sbit[19:4] : src_r, IN_BASE_REG);
    bad_src = |(phit & ~s_q.valid);
    mode_w = rd_word(SUBST_MODE_REG + {14'h0000, (s_q.st == ST_EXT) ? dcons : s_q.cons});
    wr_hit = region_hit(if_addr, IN_BASE_REG);
    led_cfg_w = rd_word(LED_CFG_REG);
    scp_w = rd_word(OUT_BASE_REG + 16'(IF_SCP * REGION_WORDS));
  end

  // ----------------------------------------------------------------
  // engine, timers, indicators, answers
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    push = 1'b0;
    push_w = '0;
    s_d.done = 1'b0;
    case (s_q.st)
      ST_SIMPLE: begin
        if (s_q.idx >= sm_len[14:0] || s_q.dst_off >= REGION_END) begin
          s_d.idx = '0;
          if (s_q.area == LAST_SAREA) begin
            s_d.area = '0;
            s_d.dst_off = '0;
            if (s_q.cons == LAST_CONS) begin
              s_d.cons = '0;
              s_d.st = ST_EXT;
            end else begin
              s_d.cons = s_q.cons + 2'd1;
            end
          end else begin
            s_d.area = s_q.area + 4'd1;
          end
        end else if (buf_ready) begin
          push_w.idx = to_idx(dst_r);
          // byte swap flag on the length word
          push_w.data = sm_len[SWAP_BIT] ? {src_w[7:0], src_w[15:8]} : src_w;
          push = 1'b1;
          if (bad_src) begin
            // zeros, ones or keep last value
            case (rmb_subst_t'(mode_w[1:0]))
              SUBST_ZERO: push_w.data = 16'h0000;
              SUBST_ONES: push_w.data = 16'hFFFF;
              default: push = 1'b0;
            endcase
          end
          s_d.idx = s_q.idx + 15'd1;
          s_d.dst_off = s_q.dst_off + 5'd1;
        end
      end
      // sixteen extended areas, one bit per step
      ST_EXT: begin
        if (s_q.idx[10:0] >= x_lim) begin
          s_d.idx = '0;
          if (s_q.area == LAST_XAREA) begin
            s_d.area = '0;
            s_d.st = ST_WRAP;
          end else begin
            s_d.area = s_q.area + 4'd1;
          end
        end else if (buf_empty) begin
          // read-modify-write needs the previous bit already stored
          push_w.idx = to_idx(dbit[19:4]);
          push_w.data = x_dw;
          push_w.data[dbit[3:0]] = bitv;
          push = (chit != 3'b000);
          if (bad_src) begin
            case (rmb_subst_t'(mode_w[1:0]))
              SUBST_ZERO: push_w.data[dbit[3:0]] = 1'b0;
              SUBST_ONES: push_w.data[dbit[3:0]] = 1'b1;
              default: push = 1'b0;
            endcase
          end
          s_d.idx = s_q.idx + 15'd1;
        end
      end
      ST_WRAP: begin
        s_d.done = 1'b1;
        s_d.st = ST_SIMPLE;
      end
      default: begin
        s_d.st = ST_SIMPLE;
      end
    endcase

    // validity timers, restarted by fresh data
    s_d.tick = (s_q.tick == TICK_LAST) ? 16'h0000 : s_q.tick + 16'h0001;
    for (int p = 0; p < NIF; p++) begin
      if (rd_word(VALID_TIME_REG + 16'(p)) == 16'h0000) begin
        s_d.valid[p] = 1'b1;
      end else if (if_we && wr_hit[p]) begin
        s_d.tmr[p] = rd_word(VALID_TIME_REG + 16'(p));
        s_d.valid[p] = 1'b1;
      end else if (s_q.tick == TICK_LAST && s_q.valid[p]) begin
        if (s_q.tmr[p] <= 16'h0001) begin
          s_d.valid[p] = 1'b0;
        end
        s_d.tmr[p] = s_q.tmr[p] - 16'h0001;
      end
    end

    s_d.led[LED_RUN] = !status_in.sys_running ? 1'b0 : (status_in.sys_initialising ? flash : 1'b1);
    s_d.led[LED_ERR] = status_in.internal_fault ? 1'b1 : (status_in.cfg_fault ? flash : 1'b0);
    s_d.led[LED_SCR_RUN] = status_in.script_running ? 1'b1 : flash;
    s_d.led[LED_SCR_ERR] = status_in.script_fault;
    // bus indicators, standby after clear data flashes
    s_d.led[LED_FB_RUN] = status_in.fb_clear_data ? flash : status_in.fb_exchange;
    s_d.led[LED_FB_STOP] = status_in.fb_offline;
    // indicators replace the first shift register only when enabled
    if (led_cfg_w[LED_EN_BIT]) begin
      s_d.sh_out = {2'b00, s_q.led};
    end else begin
      s_d.sh_out = scp_w[7:0];
    end

    // single cycle register answers
    s_d.ack = cfg_req;
    s_d.rdata = (cfg_req && !cfg_we) ? rd_word(cfg_addr) : 16'h0000;
    s_d.if_rdata = rd_word(if_rd_addr);
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_q <= '0;
      s_q.st <= ST_SIMPLE;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // word store
  // ----------------------------------------------------------------
  // any number of writers, no conflict check
  // writes land in processing order, last one wins
  always_ff @(posedge clk) begin
    if (!resetn) begin
      for (int i = 0; i < STORE_WORDS; i++) begin
        store_q[i] <= STORE_RST;
      end
    end else if (cfg_wr) begin
      store_q[to_idx(cfg_addr)] <= cfg_wdata;
    end else if (if_we && if_addr != 16'h0000 && if_addr <= STORE_LAST_REG) begin
      // low byte lane is the lower byte address
      // a byte value uses one lane, the other stays
      if (if_be[0]) begin
        store_q[to_idx(if_addr)][7:0] <= if_wdata[7:0];
      end
      if (if_be[1]) begin
        store_q[to_idx(if_addr)][15:8] <= if_wdata[15:8];
      end
    end else if (buf_valid) begin
      store_q[pop_w.idx] <= pop_w.data;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // flash phase shared by the flashing indicators, bits 0, 1, 2 and 4
  assign status_led_q = s_q.led;
  assign shift_out0_q = s_q.sh_out;
  assign cfg_rdata_q = s_q.rdata;
  assign cfg_ack_q = s_q.ack;
  assign if_rdata_q = s_q.if_rdata;
  assign producer_valid_q = s_q.valid;
  assign map_cycle_done_q = s_q.done;
endmodule
`default_nettype wire

// ---- tb/rmb_chk.sv ----
// concurrent checks on the broker ports
`default_nettype none
module rmb_chk (
  input wire logic clk, // clock
  input wire logic resetn, // reset
  input wire logic cfg_req, // strobe
  input wire logic cfg_we, // write
  input wire logic [15:0] cfg_addr, // register
  input wire logic [15:0] cfg_wdata, // word in
  input wire logic [15:0] cfg_rdata_q, // word out
  input wire logic cfg_ack_q, // done
  input wire rmb_pkg::rmb_status_t status_in, // levels
  input wire logic [7:0] shift_out0_q, // shift reg
  input wire logic [5:0] status_led_q, // leds
  input wire logic map_cycle_done_q // pass end
);
  timeunit 1ns;
  timeprecision 1ns;
  import rmb_pkg::*;
  logic en_q; // routing bit mirror
  // mirrors host writes only; interface writes there are not expected
  always_ff @(posedge clk) begin
    if (!resetn) en_q <= 1'h0;
    else if (cfg_req && cfg_we && cfg_addr == LED_CFG_REG) en_q <= cfg_wdata[LED_EN_BIT];
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  sequence routed_s;
    en_q ##1 en_q;
  endsequence
  chk_ack_next: assert property (cfg_req |=> cfg_ack_q) else $error("no ack");
  chk_unmapped_zero: assert property (cfg_req && !cfg_we && (cfg_addr == 16'h0000 || cfg_addr > STORE_LAST_REG)
    |=> cfg_rdata_q == 16'h0000) else $error("unmapped read");
  chk_run_led: assert property (!status_in.sys_initialising
    |=> status_led_q[LED_RUN] == $past(status_in.sys_running)) else $error("run led");
  chk_err_led: assert property (!status_in.cfg_fault
    |=> status_led_q[LED_ERR] == $past(status_in.internal_fault)) else $error("error led");
  chk_script_err: assert property (1'h1 |=> status_led_q[LED_SCR_ERR] == $past(status_in.script_fault))
    else $error("script led");
  chk_bus_stop: assert property (status_in.fb_offline |=> status_led_q[LED_FB_STOP]) else $error("stop led");
  chk_shift_route: assert property (routed_s |-> shift_out0_q[5:0] == $past(status_led_q))
    else $error("shift out");
  chk_done_pulse: assert property (map_cycle_done_q |=> !map_cycle_done_q) else $error("done pulse");
endmodule
bind rmb_broker rmb_chk i_rmb_chk (.clk(clk), .resetn(resetn), .cfg_req(cfg_req), .cfg_we(cfg_we),
  .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata_q(cfg_rdata_q), .cfg_ack_q(cfg_ack_q),
  .status_in(status_in), .shift_out0_q(shift_out0_q), .status_led_q(status_led_q),
  .map_cycle_done_q(map_cycle_done_q));
`default_nettype wire

// ---- tb/rmb_prod.sv ----
// producer model: an interface port writing its input region
`default_nettype none
module rmb_prod (
  input wire logic clk, // clock
  output logic if_we, // strobe
  output logic [1:0] if_be, // lanes
  output logic [15:0] if_addr, // register
  output logic [15:0] if_wdata // word
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    if_we = 1'h0;
    if_be = 2'h0;
    if_addr = 16'h0000;
    if_wdata = 16'h0000;
  end
  // one write; released data shows the inverse so stale values never match
  task automatic put(input logic [15:0] a, input logic [15:0] d, input logic [1:0] be);
    @(negedge clk);
    if_we = 1'h1;
    if_addr = a;
    if_wdata = d;
    if_be = be;
    @(negedge clk);
    if_we = 1'h0;
    if_wdata = ~d;
  endtask
endmodule
`default_nettype wire

// ---- tb/rmb_broker_tb_top.sv ----
// self-checking bench of the broker
`default_nettype none
module rmb_broker_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import rmb_pkg::*;
  logic clk = 1'h0;
  logic resetn = 1'h0;
  logic cfg_req = 1'h0;
  logic cfg_we = 1'h0;
  logic [15:0] cfg_addr = 16'h0000;
  logic [15:0] cfg_wdata = 16'h0000;
  logic [15:0] if_rd_addr = 16'h00E0;
  rmb_status_t status_in = '0;
  logic [15:0] cfg_rdata_q, if_rdata_q, if_addr, if_wdata, rd;
  logic [7:0] shift_out0_q;
  logic [5:0] status_led_q;
  logic [2:0] producer_valid_q;
  logic [1:0] if_be;
  logic cfg_ack_q, if_we, map_cycle_done_q, last;
  int err_count = 0;
  int samples_checked = 0;
  int n;
  localparam logic [31:0] MAP [8] = '{32'h0040_00C0, 32'h0041_8002, 32'h0042_00B0, 32'h0043_0001,
    32'h0070_00B0, 32'h0071_00E2, 32'h0072_0040, 32'h0073_0004};
  // overlaid word first: each new pass copies over it before its bits return
  localparam logic [31:0] EXP [4] = '{32'h00E2_00AA, 32'h00E0_5612, 32'h00E1_8899, 32'h00E3_0000};
  initial forever #50 clk = ~clk;
  rmb_broker #(.FLASH_HALF_CYC(8), .VALID_TICK_CYC(4)) i_rmb_broker (.clk(clk), .resetn(resetn),
    .cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata_q(cfg_rdata_q),
    .cfg_ack_q(cfg_ack_q), .if_we(if_we), .if_be(if_be), .if_addr(if_addr), .if_wdata(if_wdata),
    .if_rd_addr(if_rd_addr), .if_rdata_q(if_rdata_q), .status_in(status_in), .shift_out0_q(shift_out0_q),
    .status_led_q(status_led_q), .producer_valid_q(producer_valid_q), .map_cycle_done_q(map_cycle_done_q));
  rmb_prod i_rmb_prod (.clk(clk), .if_we(if_we), .if_be(if_be), .if_addr(if_addr), .if_wdata(if_wdata));
  task automatic cmp(input string s, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  // one host access from a falling edge; ack is looked at in the cycle it stands
  task automatic acc(input logic we, input logic [15:0] a, input logic [15:0] d);
    cfg_req = 1'h1;
    cfg_we = we;
    cfg_addr = a;
    cfg_wdata = d;
    @(negedge clk);
    rd = cfg_rdata_q;
    cmp("ack", 16'h0001, 16'(cfg_ack_q));
    cfg_req = 1'h0;
    @(negedge clk);
  endtask
  task automatic pass_wait(input int k);
    repeat (k) begin
      for (int i = 0; i < 4000 && map_cycle_done_q !== 1'h1; i++) @(negedge clk);
      cmp("pass_done", 16'h0001, 16'(map_cycle_done_q));
      @(negedge clk);
    end
  endtask
  task automatic summarize;
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // watchdog well beyond the expected run
  initial begin
    #5000000;
    err_count++;
    summarize();
  end
  initial begin
    repeat (5) @(negedge clk);
    resetn = 1'h1;
    acc(1'h1, 16'h0121, 16'hFFFF);
    acc(1'h0, 16'h0121, 16'h0000);
    cmp("r121", 16'h0000, rd);
    acc(1'h1, 16'h0120, 16'hA55A);
    acc(1'h0, 16'h0120, 16'h0000);
    cmp("r120", 16'hA55A, rd);
    $display("test store done");
    i_rmb_prod.put(16'h00C0, 16'h1234, 2'h3);
    i_rmb_prod.put(16'h00C0, 16'hFF56, 2'h1);
    i_rmb_prod.put(16'h00C1, 16'h9988, 2'h3);
    i_rmb_prod.put(16'h00B0, 16'h000A, 2'h3);
    acc(1'h0, 16'h00C0, 16'h0000);
    cmp("lanes", 16'h1256, rd);
    $display("test lanes done");
    for (int i = 0; i < 8; i++) acc(1'h1, MAP[i][31:16], MAP[i][15:0]);
    pass_wait(2);
    for (int i = 0; i < 4; i++) begin
      acc(1'h0, EXP[i][31:16], 16'h0000);
      cmp("map", EXP[i][15:0], rd);
    end
    cmp("ifrd", 16'h5612, if_rdata_q);
    $display("test map done");
    acc(1'h1, 16'h0031, 16'h0002);
    for (int m = 0; m < 3; m++) begin
      // keep first, so the held word is still the last valid copy
      acc(1'h1, 16'h0034, 16'((m + 2) % 3));
      pass_wait(2);
      acc(1'h0, 16'h00E0, 16'h0000);
      cmp("subst", (m == 0) ? 16'h5612 : ((m == 1) ? 16'h0000 : 16'hFFFF), rd);
    end
    cmp("stale", 16'h0000, 16'(producer_valid_q[1]));
    i_rmb_prod.put(16'h00C0, 16'h0102, 2'h3);
    cmp("fresh", 16'h0001, 16'(producer_valid_q[1]));
    $display("test subst done");
    // running, initialising, internal fault, script fault, exchange, offline
    status_in = 9'h1AD;
    acc(1'h1, 16'h0025, 16'h0001);
    n = 0;
    last = status_led_q[LED_RUN];
    for (int i = 0; i < 64; i++) begin
      @(negedge clk);
      n += (status_led_q[LED_RUN] !== last);
      last = status_led_q[LED_RUN];
    end
    cmp("flash", 16'h0001, 16'(n >= 7 && n <= 9));
    cmp("shift", 16'h0001, 16'(shift_out0_q[LED_ERR]));
    acc(1'h1, 16'h0100, 16'h00C3);
    acc(1'h1, 16'h0025, 16'h0000);
    @(negedge clk);
    cmp("unrouted", 16'h00C3, 16'(shift_out0_q));
    $display("test leds done");
    summarize();
  end
endmodule
`default_nettype wire
